// file: hw/dac_pkg.sv
// Purpose: shared constants, states and helpers for the serial converter write path
// Assumes: 16-bit command words, most significant bit first
// Notes:   code field width is a parameter of the modules, default 8

package dac_pkg;

  // command word layout
  localparam int CMD_BITS   = 16;
  localparam int BIT_IGNORE = 15;
  localparam int BIT_GAIN_N = 13;
  localparam int BIT_ACTIVE = 12;
  localparam int CODE_MSB   = 11;
  localparam int CODE_BITS  = 8;

  // serial clock edges in one command, counted from zero
  localparam logic [4:0] LAST_COUNT = 5'h0F;
  localparam logic [4:0] COUNT_ONE  = 5'h01;

  // values after reset
  localparam logic        ACTIVE_RESET   = 1'b0;
  localparam logic        GAIN_N_RESET   = 1'b0;
  localparam logic        LOAD_RES_RESET = 1'b1;
  localparam logic [11:0] CODE_RESET     = 12'h000;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [4:0]  COUNT_RESET    = 5'h00;

  // receiver states, gray along idle, shift, full
  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_SHIFT = 2'b01,
    SH_FULL  = 2'b11
  } shift_state_t;

  // rising transition between two samples
  function automatic logic rose_edge(input logic now, input logic prev);
    return now & ~prev;
  endfunction

endpackage

// file: hw/dac_cmd_if.sv
// Purpose: carries a received word and the held input register between modules
// Assumes: one clock, all signals registered at their source
// Notes:   wordValid and taken are one-cycle pulses

`timescale 1ns/10ps

interface dac_cmd_if #(
  parameter int CODE_BITS = dac_pkg::CODE_BITS
) ();
  logic                 wordValid;
  logic [15:0]          word;
  logic                 taken;
  logic                 inGainN;
  logic                 inActive;
  logic [CODE_BITS-1:0] inCode;

  modport shifter (output wordValid, output word);
  modport holder  (input wordValid, input word, output taken, output inGainN, output inActive, output inCode);
  modport user    (input wordValid, input word, input taken, input inGainN, input inActive, input inCode);
endinterface

// file: hw/serial_shifter.sv
// Purpose: receives one 16-bit command over chip select, serial clock and data
// Assumes: link inputs synchronous to clk_sys, clock far slower than clk_sys
// Notes:   a word leaves only after sixteen edges and a chip select rise

`timescale 1ns/10ps

module serial_shifter (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic   chipSelectN,
  input  wire logic   serialClock,
  input  wire logic   serialDataIn,
  dac_cmd_if.shifter  cmd
);
  dac_pkg::shift_state_t state_reg;
  dac_pkg::shift_state_t state_next;
  logic [4:0]            count_reg;
  logic [4:0]            count_next;
  logic [15:0]           shift_reg;
  logic [15:0]           shift_next;
  logic [15:0]           word_reg;
  logic [15:0]           word_next;
  logic                  valid_reg;
  logic                  valid_next;
  logic                  sclkPrev_reg;
  logic                  sclkPrev_next;
  logic                  sclkRise;

  // edge detect and receive sequence
  always_comb begin
    sclkRise      = dac_pkg::rose_edge(serialClock, sclkPrev_reg);
    sclkPrev_next = serialClock;
    state_next    = state_reg;
    count_next    = count_reg;
    shift_next    = shift_reg;
    word_next     = word_reg;
    valid_next    = 1'b0;
    case (state_reg)
      dac_pkg::SH_IDLE: begin
        if (!chipSelectN) begin
          state_next = dac_pkg::SH_SHIFT;
          count_next = dac_pkg::COUNT_RESET;
        end
      end
      dac_pkg::SH_SHIFT: begin
        if (chipSelectN) begin
          state_next = dac_pkg::SH_IDLE; // early rise drops the word
        end else if (sclkRise) begin
          shift_next = {shift_reg[14:0], serialDataIn};
          count_next = count_reg + dac_pkg::COUNT_ONE;
          if (count_reg == dac_pkg::LAST_COUNT) begin
            state_next = dac_pkg::SH_FULL;
          end
        end
      end
      dac_pkg::SH_FULL: begin
        // extra clocks ignored, word handed on at the rise
        if (chipSelectN) begin
          valid_next = 1'b1;
          word_next  = shift_reg;
          state_next = dac_pkg::SH_IDLE;
        end
      end
      default: begin
        state_next = dac_pkg::SH_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= dac_pkg::SH_IDLE;
      count_reg    <= dac_pkg::COUNT_RESET;
      shift_reg    <= dac_pkg::WORD_RESET;
      word_reg     <= dac_pkg::WORD_RESET;
      valid_reg    <= 1'b0;
      sclkPrev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      shift_reg    <= shift_next;
      word_reg     <= word_next;
      valid_reg    <= valid_next;
      sclkPrev_reg <= sclkPrev_next;
    end
  end

  assign cmd.wordValid = valid_reg;
  assign cmd.word      = word_reg;

  a_msb_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == dac_pkg::SH_SHIFT) && !chipSelectN && sclkRise |=> shift_reg[0] == $past(serialDataIn))
    else $error("serial bit not shifted in at bit zero");

  a_short_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == dac_pkg::SH_SHIFT) && chipSelectN |=> !valid_reg && (state_reg == dac_pkg::SH_IDLE))
    else $error("short transfer was not dropped");

  a_extra_clocks: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == dac_pkg::SH_FULL) && !chipSelectN |=> $stable(shift_reg) && (state_reg == dac_pkg::SH_FULL))
    else $error("clock beyond the sixteenth changed the word");

  a_latch_on_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == dac_pkg::SH_FULL) && chipSelectN |=> valid_reg && (word_reg == $past(shift_reg)))
    else $error("full word not handed on at chip select rise");
endmodule

// file: hw/input_register.sv
// Purpose: decodes an accepted command into the held input register
// Assumes: wordValid is a one-cycle pulse
// Notes:   commands with the top bit set leave everything unchanged

`timescale 1ns/10ps

module input_register #(
  parameter int CODE_BITS = dac_pkg::CODE_BITS
) (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  dac_cmd_if.holder  cmd
);
  logic                 gainN_reg;
  logic                 gainN_next;
  logic                 active_reg;
  logic                 active_next;
  logic [CODE_BITS-1:0] code_reg;
  logic [CODE_BITS-1:0] code_next;
  logic                 taken_reg;
  logic                 taken_next;

  // field capture on an accepted command
  always_comb begin
    taken_next  = cmd.wordValid && !cmd.word[dac_pkg::BIT_IGNORE];
    gainN_next  = gainN_reg;
    active_next = active_reg;
    code_next   = code_reg;
    if (taken_next) begin
      gainN_next  = cmd.word[dac_pkg::BIT_GAIN_N];
      active_next = cmd.word[dac_pkg::BIT_ACTIVE];
      code_next   = cmd.word[dac_pkg::CODE_MSB -: CODE_BITS]; // low unused bits dropped
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gainN_reg  <= dac_pkg::GAIN_N_RESET;
      active_reg <= dac_pkg::ACTIVE_RESET;
      code_reg   <= dac_pkg::CODE_RESET[CODE_BITS-1:0];
      taken_reg  <= 1'b0;
    end else begin
      gainN_reg  <= gainN_next;
      active_reg <= active_next;
      code_reg   <= code_next;
      taken_reg  <= taken_next;
    end
  end

  assign cmd.taken    = taken_reg;
  assign cmd.inGainN  = gainN_reg;
  assign cmd.inActive = active_reg;
  assign cmd.inCode   = code_reg;

  a_code_field: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmd.wordValid && !cmd.word[dac_pkg::BIT_IGNORE]
    |=> code_reg == $past(cmd.word[dac_pkg::CODE_MSB -: CODE_BITS]))
    else $error("code field not taken from the high data bits");
endmodule

// file: hw/serial_dac_write_decoder.sv
// Purpose: write side of a single-channel serial converter with double buffering
// Assumes: link pins and load strobe synchronous to clk_sys, far slower than it
// Notes:   analog stage is outside; this block drives its code, gain and mode
//
// Contract
// - commands whose top bit is one are dropped without touching any latch
// - bit 13 picks gain, one for unity, zero for double
// - bit 12 set means active, clear means shutdown
// - in shutdown the output goes to the fixed resistive load
// - bits 11 to 0 carry the code, unused low positions ignored
// - eight-bit code comes from bits 11 to 4; bit 14 ignored
// - after reset the converter stays in shutdown
// - commands arrive over chip select, serial clock and serial data
// - load strobe low copies the input register into the output register
// - load tied low updates output once a full word and chip select rise land
// - word is latched into the input register when chip select rises
// - clocks past sixteen ignored; early chip select rise aborts the word
// - link is write only, nothing is read back

`timescale 1ns/10ps

module serial_dac_write_decoder #(
  parameter int CODE_BITS = dac_pkg::CODE_BITS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 chipSelectN,
  input  wire logic                 serialClock,
  input  wire logic                 serialDataIn,
  input  wire logic                 outputLoadStrobeN,
  output logic [CODE_BITS-1:0]      converterCode,
  output logic                      gainSelectN,
  output logic                      activeEnable,
  output logic                      outputLoadResistor,
  output logic                      outputUpdate
);
  dac_cmd_if #(.CODE_BITS(CODE_BITS)) cmdBus ();

  logic [CODE_BITS-1:0] code_reg;
  logic [CODE_BITS-1:0] code_next;
  logic                 gainN_reg;
  logic                 gainN_next;
  logic                 active_reg;
  logic                 active_next;
  logic                 loadRes_reg;
  logic                 loadRes_next;
  logic                 update_reg;
  logic                 update_next;
  logic                 pending_reg;
  logic                 pending_next;
  logic                 copy;

  // receive path; no transmit pin exists, the link only writes
  serial_shifter u_shifter (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .chipSelectN  (chipSelectN),
    .serialClock  (serialClock),
    .serialDataIn (serialDataIn),
    .cmd          (cmdBus.shifter)
  );

  // held input register
  input_register #(.CODE_BITS(CODE_BITS)) u_input (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .cmd     (cmdBus.holder)
  );

  // output register copy while the strobe is low and new data waits
  always_comb begin
    copy         = !outputLoadStrobeN && pending_reg;
    pending_next = cmdBus.taken | (pending_reg & ~copy); // new word wins over the copy
    update_next  = copy;
    code_next    = code_reg;
    gainN_next   = gainN_reg;
    active_next  = active_reg;
    loadRes_next = loadRes_reg;
    if (copy) begin
      code_next    = cmdBus.inCode;
      gainN_next   = cmdBus.inGainN;
      active_next  = cmdBus.inActive;
      loadRes_next = ~cmdBus.inActive; // shutdown switches in the load
    end
  end

  // registers; shutdown held until a written word is loaded
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      code_reg    <= dac_pkg::CODE_RESET[CODE_BITS-1:0];
      gainN_reg   <= dac_pkg::GAIN_N_RESET;
      active_reg  <= dac_pkg::ACTIVE_RESET;
      loadRes_reg <= dac_pkg::LOAD_RES_RESET;
      update_reg  <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      code_reg    <= code_next;
      gainN_reg   <= gainN_next;
      active_reg  <= active_next;
      loadRes_reg <= loadRes_next;
      update_reg  <= update_next;
      pending_reg <= pending_next;
    end
  end

  // outputs straight from the registers
  assign converterCode      = code_reg;
  assign gainSelectN        = gainN_reg;
  assign activeEnable       = active_reg;
  assign outputLoadResistor = loadRes_reg;
  assign outputUpdate       = update_reg;

  // dropped command leaves the input register alone
  a_ignore_top_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdBus.wordValid && cmdBus.word[dac_pkg::BIT_IGNORE]
    |=> !cmdBus.taken && $stable(cmdBus.inCode) && $stable(cmdBus.inActive) && $stable(cmdBus.inGainN))
    else $error("command with top bit set changed a latch");

  // accepted command lands one cycle after the word
  a_take_fields: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdBus.wordValid && !cmdBus.word[dac_pkg::BIT_IGNORE]
    |=> cmdBus.taken
        && (cmdBus.inActive == $past(cmdBus.word[dac_pkg::BIT_ACTIVE]))
        && (cmdBus.inGainN == $past(cmdBus.word[dac_pkg::BIT_GAIN_N])))
    else $error("accepted command fields not held");

  // copy moves gain and code together
  a_gain_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
    copy |=> (gainN_reg == $past(cmdBus.inGainN)) && (code_reg == $past(cmdBus.inCode)))
    else $error("gain or code not copied on load");

  // resistive load tracks shutdown exactly
  a_load_resistor: assert property (@(posedge clk_sys) disable iff (!resetn)
    outputLoadResistor == !activeEnable)
    else $error("load resistor does not match shutdown");

  // first cycle after reset keeps shutdown
  a_reset_shutdown: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(resetn) |-> !activeEnable && outputLoadResistor)
    else $error("not in shutdown after reset");

  // load strobe copies pending data next cycle
  a_strobe_copies: assert property (@(posedge clk_sys) disable iff (!resetn)
    !outputLoadStrobeN && pending_reg |=> outputUpdate && (activeEnable == $past(cmdBus.inActive)))
    else $error("strobe low did not update the output register");

  // output holds while the strobe stays high
  a_strobe_high_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    outputLoadStrobeN |=> !outputUpdate && $stable(converterCode) && $stable(activeEnable))
    else $error("output changed with strobe high");

  // tied-low strobe updates two cycles after the word is taken
  a_tied_low_update: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdBus.taken ##1 !outputLoadStrobeN |=> outputUpdate && (converterCode == $past(cmdBus.inCode)))
    else $error("tied-low strobe did not update after a full word");
endmodule

// file: tb/serial_host.sv
// Purpose: host-side model that sends command words over the three-wire link
// Assumes: serial clock idles low, data changes while the serial clock is low
// Notes:   send_word takes the word and the number of serial clocks to give

`timescale 1ns/10ps

module serial_host (
  input  wire logic clk_sys,
  output logic      chipSelectN,
  output logic      serialClock,
  output logic      serialDataIn
);
  // idle link: deselected, clock parked low
  initial begin
    chipSelectN  = 1'b1;
    serialClock  = 1'b0;
    serialDataIn = 1'b0;
  end

  // one frame, top bit first, each phase held two cycles or more
  task automatic send_word(input logic [15:0] cw, input int nclk);
    int k;
    @(posedge clk_sys);
    chipSelectN <= 1'b0;
    for (k = 0; k < nclk; k++) begin
      @(posedge clk_sys);
      if (k < 16) begin
        serialDataIn <= cw[15-k];
      end else begin
        serialDataIn <= ~cw[k-16]; // surplus clocks carry junk
      end
      repeat (2) @(posedge clk_sys);
      serialClock <= 1'b1;
      repeat (2) @(posedge clk_sys);
      serialClock <= 1'b0;
    end
    @(posedge clk_sys);
    chipSelectN  <= 1'b1;
    serialDataIn <= ~serialDataIn; // released line shows no stale bit
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench for the serial converter write decoder
// Assumes: default eight-bit code width, link model in serial_host
// Notes:   random words mixed with dropped, short, long and tied-strobe frames

`timescale 1ns/10ps

module testbench;
  logic        clk_sys;
  logic        resetn;
  logic        chipSelectN;
  logic        serialClock;
  logic        serialDataIn;
  logic        outputLoadStrobeN;
  logic [7:0]  converterCode;
  logic        gainSelectN;
  logic        activeEnable;
  logic        outputLoadResistor;
  logic        outputUpdate;
  logic [7:0]  expCode;
  logic        expGain;
  logic        expActive;
  logic [15:0] w;
  int          errors;
  int          nCompared;
  int          seed;
  int          i;

  serial_dac_write_decoder u_serial_dac_write_decoder (
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .chipSelectN        (chipSelectN),
    .serialClock        (serialClock),
    .serialDataIn       (serialDataIn),
    .outputLoadStrobeN  (outputLoadStrobeN),
    .converterCode      (converterCode),
    .gainSelectN        (gainSelectN),
    .activeEnable       (activeEnable),
    .outputLoadResistor (outputLoadResistor),
    .outputUpdate       (outputUpdate)
  );

  serial_host u_serial_host (
    .clk_sys      (clk_sys),
    .chipSelectN  (chipSelectN),
    .serialClock  (serialClock),
    .serialDataIn (serialDataIn)
  );

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // expected fields of an accepted word
  function automatic void expect_word(input logic [15:0] cw);
    expCode   = cw[11:4];
    expGain   = cw[13];
    expActive = cw[12];
  endfunction

  // outputs against the expected output register
  task automatic check_fields;
    @(negedge clk_sys); // settled outputs, never on the launching edge
    chk({8'h00, converterCode}, {8'h00, expCode});
    chk({15'h0000, gainSelectN}, {15'h0000, expGain});
    chk({15'h0000, activeEnable}, {15'h0000, expActive});
    chk({15'h0000, outputLoadResistor}, {15'h0000, ~expActive});
  endtask

  // count update cycles over a window; unknown counts as high, pulse is one cycle
  task automatic watch_update(input logic want);
    int k;
    int nHigh;
    nHigh = 0;
    for (k = 0; k < 12; k++) begin
      @(negedge clk_sys);
      if (outputUpdate !== 1'b0) nHigh = nHigh + 1;
    end
    chk(16'(nHigh), {15'h0000, want});
  endtask

  // single place where the run ends
  task automatic give_verdict;
    if (errors == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog against a hung frame
  initial begin
    #400000;
    errors++;
    give_verdict;
  end

  // main sequence
  initial begin
    seed = 50505;
    errors = 0;
    nCompared = 0;
    resetn = 1'b0;
    outputLoadStrobeN = 1'b1;
    expCode = 8'h00;
    expGain = 1'b0;
    expActive = 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    check_fields;
    // strobe with nothing pending stays in shutdown
    @(posedge clk_sys);
    outputLoadStrobeN <= 1'b0;
    watch_update(1'b0);
    check_fields;
    @(posedge clk_sys);
    outputLoadStrobeN <= 1'b1;
    for (i = 0; i < 32; i++) begin
      w = 16'($random(seed));
      w[15] = 1'b0;
      if (i == 0) w = 16'h3FFF;
      if (i == 4) w = 16'h4000;
      case (i % 4)
        0: begin
          u_serial_host.send_word(w, 16);
          watch_update(1'b0);
          check_fields;
          @(posedge clk_sys);
          outputLoadStrobeN <= 1'b0;
          expect_word(w);
          watch_update(1'b1);
        end
        1: begin
          w[15] = 1'b1;
          @(posedge clk_sys);
          outputLoadStrobeN <= 1'b0;
          u_serial_host.send_word(w, 16);
          watch_update(1'b0);
        end
        2: begin
          @(posedge clk_sys);
          outputLoadStrobeN <= 1'b0;
          u_serial_host.send_word(w, 15);
          watch_update(1'b0);
        end
        default: begin
          @(posedge clk_sys);
          outputLoadStrobeN <= 1'b0;
          u_serial_host.send_word(w, 20);
          expect_word(w);
          watch_update(1'b1);
        end
      endcase
      @(posedge clk_sys);
      outputLoadStrobeN <= 1'b1;
      check_fields;
    end
    give_verdict;
  end
endmodule
